// [adcsp_pkg.sv]
// Constants shared by the converter serial port
package adcsp_pkg;
    // Serial frame layout
    localparam int unsigned BYTE_BITS      = 8;
    localparam int unsigned CMD_DECODE_BIT = 7;     // Command acted on at this falling edge
    localparam int unsigned RESULT_BITS    = 16;
    // Result codes
    localparam logic [15:0] CODE_POS_FULL  = 16'h7fff;
    localparam logic [15:0] CODE_NEG_FULL  = 16'h8000;
    // Timing, in master clock periods
    localparam int unsigned READY_PULSE_PERIODS   = 24;
    localparam int unsigned TIMEOUT_PERIODS       = 32768;  // 2^15 periods
    localparam int unsigned CLK_PER_PERIOD        = 1;      // One master clock per period
    localparam int unsigned READY_PULSE_CYCLES    = READY_PULSE_PERIODS * CLK_PER_PERIOD;
    localparam int unsigned TIMEOUT_CYCLES        = TIMEOUT_PERIODS * CLK_PER_PERIOD;
    // Reset values
    localparam logic        READY_N_RESET  = 1'b1;
    localparam logic [15:0] TX_RESET       = 16'h0000;
    localparam logic [2:0]  BIT_CNT_RESET  = 3'h0;
endpackage

// [adcsp_serial_port.sv]
// Serial target port with result-ready signalling and inactivity timeout
`timescale 1ns/1ps

// What this block does
// - Mode 1 only: idle-low clock, second-edge sampling
// - Chip select high: reset port, ignore, tristate
// - Results captured regardless of chip select
// - Ready pin ignores chip select
// - Sample falling edges, shift out rising
// - Shared output falls with ready pin
// - Ready pin high from reset
// - First serial rising edge raises ready
// - Unread result: 24-cycle high pulse first
// - New result overwrites unread one
// - Port resets without byte in 2^15
// - Timeout only while enable bit set
// - Results are 16-bit two's complement
// - Results saturate at 7fff and 8000
// - Zero gives 0000, steps give 0001/ffff
// - Works with chip select tied low
// - Command byte decoded at seventh falling edge
// - No new result accepted during register access; a pending one still loads
module adcsp_serial_port
    import adcsp_pkg::*;
#(
    parameter int unsigned RAW_W       = 24,
    parameter int unsigned TIMEOUT_CNT = TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Serial pins from the host
    input  wire logic             cs_n_in,
    input  wire logic             sclk_in,
    input  wire logic             din_in,
    // Shared data and ready pin
    output logic                  shared_data_out_ready_pin_out,
    output logic                  shared_data_out_ready_pin_oe_out,
    // Dedicated ready pin, active low
    output logic                  result_ready_pin_n_out,
    // Conversion engine side
    input  wire logic [RAW_W-1:0] conv_result_in,
    input  wire logic             conv_done_in,
    input  wire logic             timeout_en_in,
    // Command decoder side
    input  wire logic             reg_busy_in,
    input  wire logic             reg_load_in,
    input  wire logic [7:0]       reg_data_in,
    output logic                  cmd_strobe_out,
    output logic [6:0]            cmd_bits_out,
    output logic                  byte_strobe_out,
    output logic [7:0]            byte_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    localparam logic [4:0]  PULSE_LAST = 5'(READY_PULSE_CYCLES - 1);
    localparam int unsigned TO_W       = $clog2(TIMEOUT_CNT + 1);
    localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CNT - 1);
    localparam logic [2:0]  CMD_CNT    = 3'(CMD_DECODE_BIT - 1);
    localparam logic [2:0]  BYTE_LAST  = 3'(BYTE_BITS - 1);

    // Saturate a wide signed result into the 16-bit output code
    function automatic logic [15:0] adcsp_sat(input logic [RAW_W-1:0] raw);
        logic signed [RAW_W-1:0] s;
        s = signed'(raw);
        if (s > signed'(RAW_W'(CODE_POS_FULL))) begin
            adcsp_sat = CODE_POS_FULL;
        end else if (s < -signed'(RAW_W'(CODE_POS_FULL)) - 1) begin
            adcsp_sat = CODE_NEG_FULL;
        end else begin
            adcsp_sat = raw[15:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [1:0] sclk_sync_ff;
    logic [1:0] cs_sync_ff;
    logic [1:0] din_sync_ff;
    logic       sclk_prev_ff;

    // Two flops per pin before any logic
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_sync_ff <= 2'h0;
            cs_sync_ff   <= 2'h3;
            din_sync_ff  <= 2'h0;
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], sclk_in};
            cs_sync_ff   <= {cs_sync_ff[0], cs_n_in};
            din_sync_ff  <= {din_sync_ff[0], din_in};
            sclk_prev_ff <= sclk_sync_ff[1];
        end
    end

    logic cs_act;
    logic sclk_rise;
    logic sclk_fall;
    logic din_s;
    logic to_hit;

    assign cs_act    = !cs_sync_ff[1];
    assign sclk_rise = cs_act && sclk_sync_ff[1] && !sclk_prev_ff;
    assign sclk_fall = cs_act && !sclk_sync_ff[1] && sclk_prev_ff;
    assign din_s     = din_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Receive path

    logic [2:0] bit_cnt_ff;
    logic [6:0] rx_sr_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bit_cnt_ff      <= BIT_CNT_RESET;
            rx_sr_ff        <= 7'h00;
            cmd_strobe_out  <= 1'b0;
            cmd_bits_out    <= 7'h00;
            byte_strobe_out <= 1'b0;
            byte_out        <= 8'h00;
        end else begin
            cmd_strobe_out  <= 1'b0;
            byte_strobe_out <= 1'b0;
            if (!cs_act || to_hit) begin
                bit_cnt_ff <= BIT_CNT_RESET;
            end else if (sclk_fall) begin
                rx_sr_ff   <= {rx_sr_ff[5:0], din_s};
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == CMD_CNT) begin
                    cmd_strobe_out <= 1'b1;
                    cmd_bits_out   <= {rx_sr_ff[5:0], din_s};
                end
                if (bit_cnt_ff == BYTE_LAST) begin
                    byte_strobe_out <= 1'b1;
                    byte_out        <= {rx_sr_ff, din_s};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Inactivity timeout

    logic [TO_W-1:0] to_cnt_ff;
    logic            byte_done;

    assign byte_done = sclk_fall && (bit_cnt_ff == BYTE_LAST);
    assign to_hit    = timeout_en_in && (to_cnt_ff == TO_LAST);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            to_cnt_ff <= '0;
        end else if (!timeout_en_in || !cs_act || byte_done || to_hit) begin
            to_cnt_ff <= '0;
        end else begin
            to_cnt_ff <= to_cnt_ff + TO_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result capture and ready pulse

    logic [15:0] res_ff;
    logic        pend_ff;
    logic [4:0]  pulse_cnt_ff;
    logic        accept;
    logic        load_now;
    logic [15:0] load_val;

    assign accept   = conv_done_in && !reg_busy_in;
    assign load_now = (accept && result_ready_pin_n_out && !pend_ff)
                   || (pend_ff && pulse_cnt_ff == PULSE_LAST);
    assign load_val = (pend_ff && !accept) ? res_ff : adcsp_sat(conv_result_in);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            res_ff <= TX_RESET;
        end else if (accept) begin
            res_ff <= adcsp_sat(conv_result_in);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_ff      <= 1'b0;
            pulse_cnt_ff <= 5'h00;
        end else if (load_now) begin
            pend_ff      <= 1'b0;
            pulse_cnt_ff <= 5'h00;
        end else if (pend_ff) begin
            pulse_cnt_ff <= pulse_cnt_ff + 5'h01;
        end else if (accept && !result_ready_pin_n_out) begin
            pend_ff      <= 1'b1;
            pulse_cnt_ff <= 5'h00;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            result_ready_pin_n_out <= READY_N_RESET;
        end else if (load_now) begin
            result_ready_pin_n_out <= 1'b0;
        end else if (sclk_rise || (accept && !pend_ff)) begin
            result_ready_pin_n_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit path

    logic [15:0] tx_sr_ff;
    logic        tx_act_ff;

    // works with chip select tied low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_sr_ff                      <= TX_RESET;
            tx_act_ff                     <= 1'b0;
            shared_data_out_ready_pin_out <= READY_N_RESET;
        end else if (load_now) begin
            tx_sr_ff                      <= load_val;
            tx_act_ff                     <= 1'b0;
            shared_data_out_ready_pin_out <= 1'b0;
        end else if (reg_load_in) begin
            tx_sr_ff <= {reg_data_in, 8'h00};
        end else if (!cs_act || to_hit) begin
            tx_act_ff                     <= 1'b0;
            shared_data_out_ready_pin_out <= result_ready_pin_n_out;
        end else if (sclk_rise) begin
            tx_act_ff                     <= 1'b1;
            tx_sr_ff                      <= {tx_sr_ff[14:0], 1'b0};
            shared_data_out_ready_pin_out <= tx_sr_ff[15];
        end else if (!tx_act_ff) begin
            shared_data_out_ready_pin_out <= result_ready_pin_n_out;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shared_data_out_ready_pin_oe_out <= 1'b0;
        end else begin
            shared_data_out_ready_pin_oe_out <= cs_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    logic seen_load_ff;

    // Notes whether any result has been presented
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_load_ff <= 1'b0;
        end else if (load_now) begin
            seen_load_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_DESELECT_HIZ: assert property (
        cs_sync_ff[1] |=> !shared_data_out_ready_pin_oe_out)
        else $error("Shared pin driven while deselected");

    AST_READY_HIGH_INIT: assert property (
        !seen_load_ff |-> result_ready_pin_n_out)
        else $error("Ready low before any result");

    AST_FALL_TOGETHER: assert property (
        load_now && cs_act |=> !shared_data_out_ready_pin_out && !result_ready_pin_n_out)
        else $error("Shared pin did not fall with ready pin");

    AST_SCLK_RAISES: assert property (
        !result_ready_pin_n_out && sclk_rise && !load_now |=> result_ready_pin_n_out)
        else $error("Ready not raised by serial rising edge");

    AST_PULSE_LEN: assert property (
        accept && !result_ready_pin_n_out && !pend_ff
        |=> result_ready_pin_n_out [*8] ##16 load_now)
        else $error("Unread result pulse wrong length");

    AST_CMD_SEVENTH: assert property (
        sclk_fall && !to_hit && bit_cnt_ff == CMD_CNT
        |=> cmd_strobe_out && cmd_bits_out[0] == $past(din_s))
        else $error("Command not decoded on seventh edge");

    AST_BLOCK_LOAD: assert property (
        conv_done_in && reg_busy_in && !pend_ff |=> !$fell(result_ready_pin_n_out))
        else $error("Result loaded during register access");

    AST_TIMEOUT_OFF: assert property (
        !timeout_en_in |=> to_cnt_ff == '0)
        else $error("Timeout counter ran while disabled");

    AST_TIMEOUT_RESET: assert property (
        to_hit |=> bit_cnt_ff == BIT_CNT_RESET && to_cnt_ff == '0)
        else $error("Timeout did not reset the port");

    AST_CLIP_POS: assert property (
        accept && signed'(conv_result_in) > signed'(RAW_W'(CODE_POS_FULL))
        |=> res_ff == CODE_POS_FULL)
        else $error("Positive overrange not clipped");

    AST_CLIP_NEG: assert property (
        accept && signed'(conv_result_in) < -signed'(RAW_W'(CODE_POS_FULL)) - 1
        |=> res_ff == CODE_NEG_FULL)
        else $error("Negative overrange not clipped");

    AST_PEND_HIGH: assert property (
        pend_ff |-> result_ready_pin_n_out)
        else $error("Ready low during unread pulse");

    AST_READY_DESELECTED: assert property (
        load_now && !cs_act |=> !result_ready_pin_n_out)
        else $error("Ready pin gated by chip select");

    AST_BYTE_EIGHTH: assert property (
        sclk_fall && !to_hit && bit_cnt_ff == BYTE_LAST
        |=> byte_strobe_out && byte_out[0] == $past(din_s))
        else $error("Byte not completed on eighth edge");

endmodule

// [adcsp_host_model.sv]
// Mode 1 serial host that frames transfers to the converter serial port
`timescale 1ns/1ps
module adcsp_host_model #(
    parameter int HALF_CLKS = 4
) (
    // Master clock and returned data
    input  wire logic clk_in,
    input  wire logic sdo_in,
    // Serial pins toward the port
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    // Idle pins: deselected, clock parked low, data low
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out  = 1'b0;
    end
    // Select level held until the caller changes it
    task automatic select_dev(input logic level_n);
        @(posedge clk_in);
        cs_n_out <= level_n;
        repeat (HALF_CLKS) @(posedge clk_in);
    endtask
    // Idle-low clock, data set on rise, taken on fall
    task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        for (int i = nbits - 1; i >= 0; i--) begin
            @(posedge clk_in);
            sclk_out <= 1'b1;
            din_out  <= tx[i];
            repeat (HALF_CLKS) @(posedge clk_in);
            sclk_out <= 1'b0;
            repeat (2) @(posedge clk_in);
            #1;
            rx = {rx[14:0], sdo_in};
            repeat (HALF_CLKS - 3) @(posedge clk_in);
        end
        // Clock stays low, data input back low
        din_out <= 1'b0;
    endtask
endmodule

// [adc_serial_port_data_ready_bench.sv]
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
module adc_serial_port_data_ready_bench import adcsp_pkg::*; ;
    localparam int TO_CNT = 200;
    // Stimulus, given its first values by the main sequence
    logic        clk_in;
    logic        rst_in;
    logic        conv_done;
    logic        timeout_en;
    logic        reg_busy;
    logic        reg_load;
    logic [23:0] conv_result;
    logic [7:0]  reg_data;
    // Pins between host and port
    logic        cs_n;
    logic        sclk;
    logic        din;
    logic        sdo_val;
    logic        sdo_oe;
    logic        ready_n;
    wire         sdo_w;
    // Decoder side outputs and captures
    logic        cmd_strobe;
    logic        byte_strobe;
    logic [7:0]  byte_out;
    logic [7:0]  last_byte = 8'h00;
    logic [6:0]  cmd_bits;
    logic [6:0]  last_cmd = 7'h00;
    logic [15:0] rx;
    int          err_total = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [23:0] raw_tab [5] = '{24'h7fffff, 24'h800000, 24'h000000, 24'h000001, 24'hffffff};
    logic [15:0] exp_tab [5] = '{CODE_POS_FULL, CODE_NEG_FULL, 16'h0000, 16'h0001, 16'hffff};

    // Released shared pin floats
    assign sdo_w = sdo_oe ? sdo_val : 1'bz;

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    always #12.5 clk_in = ~clk_in;
    adcsp_serial_port #(
        .RAW_W      (24),
        .TIMEOUT_CNT(TO_CNT)
    ) DUT (
        .clk_in                          (clk_in),
        .rst_in                          (rst_in),
        .cs_n_in                         (cs_n),
        .sclk_in                         (sclk),
        .din_in                          (din),
        .shared_data_out_ready_pin_out   (sdo_val),
        .shared_data_out_ready_pin_oe_out(sdo_oe),
        .result_ready_pin_n_out          (ready_n),
        .conv_result_in                  (conv_result),
        .conv_done_in                    (conv_done),
        .timeout_en_in                   (timeout_en),
        .reg_busy_in                     (reg_busy),
        .reg_load_in                     (reg_load),
        .reg_data_in                     (reg_data),
        .cmd_strobe_out                  (cmd_strobe),
        .cmd_bits_out                    (cmd_bits),
        .byte_strobe_out                 (byte_strobe),
        .byte_out                        (byte_out)
    );
    adcsp_host_model host (
        .clk_in  (clk_in),
        .sdo_in  (sdo_w),
        .cs_n_out(cs_n),
        .sclk_out(sclk),
        .din_out (din)
    );
    // Capture decoded command bits and bytes on their strobes
    always @(posedge clk_in) begin
        if (cmd_strobe === 1'b1) last_cmd <= cmd_bits;
        if (byte_strobe === 1'b1) last_byte <= byte_out;
    end
    // Hang guard
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counted comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One-cycle result pulse from the engine
    task automatic conv(input logic [23:0] val);
        @(posedge clk_in);
        conv_result <= val;
        conv_done   <= 1'b1;
        @(posedge clk_in);
        conv_done <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Both saturation codes, zero and the two steps read with chip select low
    task automatic t_codes();
        host.select_dev(1'b0);
        for (int i = 0; i < 5; i++) begin
            conv(raw_tab[i]);
            chk({13'h0, ready_n, sdo_oe, sdo_val}, 16'h0002, "ready fall");
            host.xfer(16, 16'h0000, rx);
            chk(rx, exp_tab[i], "result code");
            chk({15'h0, ready_n}, 16'h0001, "ready raise");
        end
        host.select_dev(1'b1);
        #1;
        chk({15'h0, sdo_oe}, 16'h0000, "released");
    endtask
    // Result arriving while deselected
    task automatic t_deselected();
        conv(24'h000123);
        chk({14'h0, ready_n, sdo_oe}, 16'h0000, "ready while deselected");
        host.select_dev(1'b0);
        host.xfer(16, 16'h0000, rx);
        chk(rx, 16'h0123, "captured while deselected");
        host.select_dev(1'b1);
    endtask
    // Unread result replaced after the high pulse
    task automatic t_unread();
        conv(24'h000011);
        repeat (30) @(posedge clk_in);
        conv(24'h000022);
        chk({15'h0, ready_n}, 16'h0001, "pulse start");
        repeat (23) @(posedge clk_in);
        #1;
        chk({15'h0, ready_n}, 16'h0001, "pulse held");
        @(posedge clk_in);
        #1;
        chk({15'h0, ready_n}, 16'h0000, "pulse end");
        host.select_dev(1'b0);
        host.xfer(16, 16'h0000, rx);
        chk(rx, 16'h0022, "newest kept");
        host.select_dev(1'b1);
    endtask
    // Result blocked during register access, then a register byte out
    task automatic t_busy_load();
        @(posedge clk_in);
        reg_busy <= 1'b1;
        conv(24'h000055);
        repeat (3) @(posedge clk_in);
        reg_busy <= 1'b0;
        #1;
        chk({15'h0, ready_n}, 16'h0001, "blocked load");
        @(posedge clk_in);
        reg_data <= 8'h3c;
        reg_load <= 1'b1;
        @(posedge clk_in);
        reg_load <= 1'b0;
        host.select_dev(1'b0);
        host.xfer(8, 16'h0000, rx);
        chk(rx, 16'h003c, "register byte");
        host.select_dev(1'b1);
    endtask
    // Command byte decode
    task automatic t_command();
        // A partial byte cut by deselection must be dropped
        host.select_dev(1'b0);
        host.xfer(3, 16'h0007, rx);
        host.select_dev(1'b1);
        host.select_dev(1'b0);
        host.xfer(8, 16'h00a5, rx);
        repeat (6) @(posedge clk_in);
        chk({9'h0, last_cmd}, 16'h0052, "command bits");
        chk({8'h0, last_byte}, 16'h00a5, "command byte");
        host.select_dev(1'b1);
    endtask
    // Partial byte dropped by timeout with select tied low
    task automatic t_timeout();
        @(posedge clk_in);
        timeout_en <= 1'b1;
        host.select_dev(1'b0);
        host.xfer(3, 16'h0007, rx);
        repeat (TO_CNT + 20) @(posedge clk_in);
        host.xfer(8, 16'h0081, rx);
        repeat (6) @(posedge clk_in);
        chk({8'h0, last_byte}, 16'h0081, "byte after timeout");
        @(posedge clk_in);
        timeout_en <= 1'b0;
        host.select_dev(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk_in      = 1'b0;
        rst_in      = 1'b1;
        conv_done   = 1'b0;
        timeout_en  = 1'b0;
        reg_busy    = 1'b0;
        reg_load    = 1'b0;
        conv_result = 24'h000000;
        reg_data    = 8'h00;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        chk({14'h0, ready_n, sdo_oe}, 16'h0002, "reset state");
        t_codes();
        t_deselected();
        t_unread();
        t_busy_load();
        t_command();
        t_timeout();
        report_and_stop();
    end
endmodule
